// file: src/lin_host_pkg.sv
// constants and types shared by the transceiver mode controller
package lin_host_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMER_W = 16;
  // delay between the data pin and the enable pin at mode selection, least time 5.0 us
  localparam int T_MODE_SEL_NS = 5000;
  localparam int MODE_SEL_CYC = (T_MODE_SEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // first data edge after mode selection, least time 50 us
  localparam int T_FIRST_TXD_NS = 50000;
  localparam int FIRST_TXD_CYC = (T_FIRST_TXD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // sleep filter, least time 50 us
  localparam int T_SLEEP_DELAY_NS = 50000;
  localparam int SLEEP_DELAY_CYC = (T_SLEEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // whole fast toggle sequence, longest time 35 us, spent as three steps with margin
  localparam int T_TOGGLE_MAX_NS = 35000;
  localparam int TOGGLE_MAX_CYC = T_TOGGLE_MAX_NS / CLK_PERIOD_NS;
  localparam int TOGGLE_STEP_CYC = TOGGLE_MAX_CYC / 8;
  // enable glitch leaving fast mode, longest time 5.0 us, half of it used
  localparam int T_GLITCH_MAX_NS = 5000;
  localparam int GLITCH_MAX_CYC = T_GLITCH_MAX_NS / CLK_PERIOD_NS;
  localparam int GLITCH_CYC = GLITCH_MAX_CYC / 2;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    MODE_SLEEP, MODE_AWAKE, MODE_NORMAL, MODE_WAIT_SLOW, MODE_SLOW, MODE_FAST
  } mode_t;

  typedef enum logic [2:0] {
    CMD_NORMAL, CMD_SLOW, CMD_SLEEP, CMD_FAST_TOGGLE, CMD_FAST_GLITCH
  } cmd_t;

  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_PRESET, SEQ_SETTLE, SEQ_SLEEP_PRE, SEQ_SLEEP_WAIT,
    SEQ_TOG_PRE, SEQ_TOG_LOW, SEQ_TOG_HIGH, SEQ_GLITCH
  } seq_t;
endpackage : lin_host_pkg

// file: src/pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= '1;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level = level_q;
endmodule : pin_sync
`default_nettype wire

// file: src/lin_mode_host.sv
// host controller that drives the transceiver data and enable pins through its modes
`timescale 1ns/1ps
`default_nettype none
module lin_mode_host #(
  parameter int FIRST_TXD_CYC = lin_host_pkg::FIRST_TXD_CYC,
  parameter int SLEEP_DELAY_CYC = lin_host_pkg::SLEEP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic tx_bit,
  output logic cmd_ready,
  output logic cmd_err,
  output logic wake_evt,
  output logic rx_bit,
  output lin_host_pkg::mode_t mode,
  output logic txd_pin,
  output logic en_pin,
  input wire logic rxd_pin,
  input wire logic regulator_gate_out
);
  localparam int TW = lin_host_pkg::TIMER_W;
  lin_host_pkg::seq_t seq_q;
  lin_host_pkg::mode_t mode_q;
  lin_host_pkg::mode_t prev_q;
  lin_host_pkg::mode_t tgt_q;
  logic [TW-1:0] cnt_q;
  logic txd_q;
  logic en_q;
  logic ready_q;
  logic err_q;
  logic wake_q;
  logic rx_q;
  logic [1:0] pins_s;
  logic rxd_s;
  logic gate_s;
  logic idle;
  logic accept;
  logic wake_seen;

  function automatic logic [TW-1:0] load(input int n);
    load = TW'(n - 1);
  endfunction : load
  function automatic logic is_active(input lin_host_pkg::mode_t m);
    is_active = (m == lin_host_pkg::MODE_NORMAL) || (m == lin_host_pkg::MODE_SLOW) ||
                (m == lin_host_pkg::MODE_FAST);
  endfunction : is_active
  function automatic logic legal(input logic [2:0] c, input lin_host_pkg::mode_t m);
    case (c)
      lin_host_pkg::CMD_NORMAL, lin_host_pkg::CMD_SLOW: begin
        // only from sleep or awake, never between normal and slow
        legal = (m == lin_host_pkg::MODE_SLEEP) || (m == lin_host_pkg::MODE_AWAKE);
      end
      lin_host_pkg::CMD_SLEEP: legal = (m != lin_host_pkg::MODE_SLEEP);
      lin_host_pkg::CMD_FAST_TOGGLE: legal = is_active(m);
      lin_host_pkg::CMD_FAST_GLITCH: legal = (m == lin_host_pkg::MODE_FAST);
      default: legal = 1'b0;
    endcase
  endfunction : legal

  pin_sync #(.W(lin_host_pkg::SYNC_STAGES - 1)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({rxd_pin, regulator_gate_out}),
    .level(pins_s)
  );
  assign rxd_s = pins_s[1];
  assign gate_s = pins_s[0];
  assign idle = (seq_q == lin_host_pkg::SEQ_IDLE);
  assign accept = cmd_valid && idle && legal(cmd_code, mode_q);
  // receive pulled low while the gate output is high reports a bus or wake pin wake-up
  assign wake_seen = idle && (mode_q == lin_host_pkg::MODE_SLEEP) && !rxd_s && gate_s;

  // mode sequencer: owns the pins, the timer and the tracked device mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= lin_host_pkg::SEQ_IDLE;
      mode_q <= lin_host_pkg::MODE_AWAKE;
      prev_q <= lin_host_pkg::MODE_NORMAL;
      tgt_q <= lin_host_pkg::MODE_NORMAL;
      cnt_q <= '0;
      txd_q <= 1'b1;
      en_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      case (seq_q)
        lin_host_pkg::SEQ_IDLE: begin
          ready_q <= 1'b1;
          if (is_active(mode_q)) begin
            txd_q <= tx_bit;
          end
          if (wake_seen) begin
            mode_q <= lin_host_pkg::MODE_AWAKE;
          end else if (accept) begin
            ready_q <= 1'b0;
            case (cmd_code)
              lin_host_pkg::CMD_NORMAL, lin_host_pkg::CMD_SLOW: begin
                // data level set first, enable rises only after the selection delay
                txd_q <= (cmd_code == lin_host_pkg::CMD_NORMAL);
                tgt_q <= (cmd_code == lin_host_pkg::CMD_NORMAL) ? lin_host_pkg::MODE_NORMAL :
                         lin_host_pkg::MODE_SLOW;
                cnt_q <= load(lin_host_pkg::MODE_SEL_CYC);
                seq_q <= lin_host_pkg::SEQ_PRESET;
              end
              lin_host_pkg::CMD_SLEEP: begin
                txd_q <= 1'b1;
                cnt_q <= load(lin_host_pkg::MODE_SEL_CYC);
                seq_q <= lin_host_pkg::SEQ_SLEEP_PRE;
              end
              lin_host_pkg::CMD_FAST_TOGGLE: begin
                txd_q <= 1'b0;
                cnt_q <= load(lin_host_pkg::TOGGLE_STEP_CYC);
                seq_q <= lin_host_pkg::SEQ_TOG_PRE;
              end
              default: begin
                en_q <= 1'b0;
                cnt_q <= load(lin_host_pkg::GLITCH_CYC);
                seq_q <= lin_host_pkg::SEQ_GLITCH;
              end
            endcase
          end
        end
        lin_host_pkg::SEQ_PRESET: begin
          if (cnt_q == '0) begin
            en_q <= 1'b1;
            mode_q <= (tgt_q == lin_host_pkg::MODE_NORMAL) ? lin_host_pkg::MODE_NORMAL :
                      lin_host_pkg::MODE_WAIT_SLOW;
            cnt_q <= load(FIRST_TXD_CYC);
            seq_q <= lin_host_pkg::SEQ_SETTLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        lin_host_pkg::SEQ_SETTLE: begin
          if (cnt_q == '0) begin
            prev_q <= tgt_q;
            if (mode_q == lin_host_pkg::MODE_WAIT_SLOW) begin
              // first data rising edge moves the device out of wait slow
              txd_q <= 1'b1;
              mode_q <= lin_host_pkg::MODE_SLOW;
            end
            seq_q <= lin_host_pkg::SEQ_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        lin_host_pkg::SEQ_SLEEP_PRE: begin
          if (cnt_q == '0) begin
            en_q <= 1'b0;
            cnt_q <= load(SLEEP_DELAY_CYC);
            seq_q <= lin_host_pkg::SEQ_SLEEP_WAIT;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        lin_host_pkg::SEQ_SLEEP_WAIT: begin
          if (cnt_q == '0) begin
            mode_q <= lin_host_pkg::MODE_SLEEP;
            seq_q <= lin_host_pkg::SEQ_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        lin_host_pkg::SEQ_TOG_PRE: begin
          if (cnt_q == '0) begin
            en_q <= 1'b0;
            cnt_q <= load(lin_host_pkg::TOGGLE_STEP_CYC);
            seq_q <= lin_host_pkg::SEQ_TOG_LOW;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        lin_host_pkg::SEQ_TOG_LOW: begin
          if (cnt_q == '0) begin
            txd_q <= 1'b1;
            cnt_q <= load(lin_host_pkg::TOGGLE_STEP_CYC);
            seq_q <= lin_host_pkg::SEQ_TOG_HIGH;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        lin_host_pkg::SEQ_TOG_HIGH: begin
          if (cnt_q == '0) begin
            // three short steps keep the sequence well inside its limit
            en_q <= 1'b1;
            mode_q <= (mode_q == lin_host_pkg::MODE_FAST) ? prev_q : lin_host_pkg::MODE_FAST;
            seq_q <= lin_host_pkg::SEQ_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        lin_host_pkg::SEQ_GLITCH: begin
          if (cnt_q == '0) begin
            en_q <= 1'b1;
            mode_q <= prev_q;
            seq_q <= lin_host_pkg::SEQ_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          seq_q <= lin_host_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // status flags towards the user
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
      wake_q <= 1'b0;
      rx_q <= 1'b1;
    end else begin
      err_q <= cmd_valid && idle && !wake_seen && !legal(cmd_code, mode_q);
      wake_q <= wake_seen;
      rx_q <= rxd_s;
    end
  end

  assign cmd_ready = ready_q;
  assign cmd_err = err_q;
  assign wake_evt = wake_q;
  assign rx_bit = rx_q;
  assign mode = mode_q;
  assign txd_pin = txd_q;
  assign en_pin = en_q;
  int tog_len;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_len <= 0;
    end else if (seq_q == lin_host_pkg::SEQ_TOG_PRE || seq_q == lin_host_pkg::SEQ_TOG_LOW ||
                 seq_q == lin_host_pkg::SEQ_TOG_HIGH) begin
      tog_len <= tog_len + 1;
    end else begin
      tog_len <= 0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_sleep_wait_pins: assert property (seq_q == lin_host_pkg::SEQ_SLEEP_WAIT |-> txd_q && !en_q)
    else $error("sleep wait without data high and enable low");
  a_normal_data_first: assert property ($rose(en_q) && mode_q == lin_host_pkg::MODE_NORMAL
      && $past(mode_q) != lin_host_pkg::MODE_FAST |-> $past(txd_q) && $past(seq_q) == lin_host_pkg::SEQ_PRESET)
    else $error("normal selected without data high before enable");
  a_slow_data_first: assert property ($rose(en_q) && mode_q == lin_host_pkg::MODE_WAIT_SLOW
      |-> !$past(txd_q))
    else $error("wait slow selected without data low before enable");
  a_refuse_switch: assert property (cmd_valid && idle && !wake_seen && is_active(mode_q) &&
      (cmd_code == lin_host_pkg::CMD_NORMAL || cmd_code == lin_host_pkg::CMD_SLOW)
      |=> err_q && seq_q == lin_host_pkg::SEQ_IDLE && mode_q == $past(mode_q))
    else $error("switch between normal and slow not refused");
  a_toggle_bound: assert property (tog_len < lin_host_pkg::TOGGLE_MAX_CYC)
    else $error("fast toggle sequence too long");
  a_toggle_enters: assert property (seq_q == lin_host_pkg::SEQ_TOG_HIGH && cnt_q == '0 &&
      mode_q != lin_host_pkg::MODE_FAST |=> mode_q == lin_host_pkg::MODE_FAST && $rose(en_q) && txd_q)
    else $error("toggle did not enter fast mode");
  a_glitch_short: assert property ($fell(en_q) && seq_q == lin_host_pkg::SEQ_GLITCH
      |-> ##[1:499] $rose(en_q) && mode_q == prev_q)
    else $error("enable glitch too long or wrong mode restored");
  a_wake_awake: assert property (wake_seen |=> mode_q == lin_host_pkg::MODE_AWAKE && wake_q)
    else $error("wake report not followed by awake");
  a_active_data: assert property (idle && is_active(mode_q) && !cmd_valid |=> txd_q == $past(tx_bit))
    else $error("data pin does not follow transmit bit");
  a_wait_slow_exit: assert property (seq_q == lin_host_pkg::SEQ_SETTLE && cnt_q == '0 &&
      mode_q == lin_host_pkg::MODE_WAIT_SLOW |=> mode_q == lin_host_pkg::MODE_SLOW && $rose(txd_q))
    else $error("wait slow not left on first data rise");
  a_sleep_en_low: assert property (mode_q == lin_host_pkg::MODE_SLEEP |-> !en_q)
    else $error("enable high while device asleep");
  c_fast_entry: cover property ($changed(mode_q) && mode_q == lin_host_pkg::MODE_FAST);
  c_sleep_entry: cover property ($changed(mode_q) && mode_q == lin_host_pkg::MODE_SLEEP);
  c_slow_entry: cover property ($changed(mode_q) && mode_q == lin_host_pkg::MODE_SLOW);
  c_wake: cover property (wake_q);
endmodule : lin_mode_host
`default_nettype wire

// file: sim/lin_dev_model.sv
// behavioural model of the transceiver pins that face the host controller
`timescale 1ns/1ps
`default_nettype none
module lin_dev_model #(
  parameter int WAKE_CYC = 4000,
  parameter int BUS_CYC = 7000,
  parameter int SD_CYC = 600
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic txd,
  input wire logic en,
  input wire logic wake_pin,
  input wire logic bus_pull_dn,
  output logic rxd,
  output logic gate,
  output logic bus,
  output lin_host_pkg::mode_t dmode
);
  lin_host_pkg::mode_t prev_q;
  logic en_q, txd_q, txd_fall_q, ref_q, drv, rise;
  int low_q, wk_q, dom_q;
  assign drv = dmode inside {lin_host_pkg::MODE_NORMAL, lin_host_pkg::MODE_SLOW, lin_host_pkg::MODE_FAST};
  assign bus = !bus_pull_dn && !(drv && !txd);
  assign gate = dmode != lin_host_pkg::MODE_SLEEP;
  // floating receive output in sleep reads high through the host pull-up
  assign rxd = (dmode == lin_host_pkg::MODE_AWAKE) ? 1'b0 : (drv ? bus : 1'b1);
  assign rise = en && !en_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmode <= lin_host_pkg::MODE_AWAKE;
      prev_q <= lin_host_pkg::MODE_NORMAL;
      en_q <= 1'b0;
      txd_q <= 1'b1;
      txd_fall_q <= 1'b0;
      ref_q <= 1'b0;
      low_q <= 0;
      wk_q <= 0;
      dom_q <= 0;
    end else begin
      en_q <= en;
      txd_q <= txd;
      if (en_q && !en) txd_fall_q <= txd;
      low_q <= en ? 0 : low_q + 1;
      wk_q <= (dmode == lin_host_pkg::MODE_SLEEP && wake_pin != ref_q) ? wk_q + 1 : 0;
      dom_q <= !bus ? dom_q + 1 : 0;
      case (dmode)
        lin_host_pkg::MODE_SLEEP, lin_host_pkg::MODE_AWAKE: begin
          if (rise) begin
            dmode <= txd ? lin_host_pkg::MODE_NORMAL : lin_host_pkg::MODE_WAIT_SLOW;
            prev_q <= txd ? lin_host_pkg::MODE_NORMAL : lin_host_pkg::MODE_SLOW;
          end else if (dmode == lin_host_pkg::MODE_SLEEP && (wk_q >= WAKE_CYC || (bus && dom_q > BUS_CYC))) begin
            dmode <= lin_host_pkg::MODE_AWAKE;
          end
        end
        lin_host_pkg::MODE_WAIT_SLOW: if (txd && !txd_q) dmode <= lin_host_pkg::MODE_SLOW;
        lin_host_pkg::MODE_NORMAL, lin_host_pkg::MODE_SLOW: begin
          // any other enable rise keeps the chosen rate
          if (rise && !txd_fall_q && txd && low_q < lin_host_pkg::TOGGLE_MAX_CYC) dmode <= lin_host_pkg::MODE_FAST;
        end
        lin_host_pkg::MODE_FAST: begin
          if (rise && (low_q < lin_host_pkg::GLITCH_MAX_CYC || (!txd_fall_q && txd))) dmode <= prev_q;
        end
        default: ;
      endcase
      if (!en && txd_fall_q && low_q == SD_CYC && dmode != lin_host_pkg::MODE_SLEEP && dmode != lin_host_pkg::MODE_AWAKE) begin
        dmode <= lin_host_pkg::MODE_SLEEP;
        ref_q <= wake_pin;
      end
    end
  end
endmodule : lin_dev_model
`default_nettype wire

// file: sim/lin_mode_host_tb.sv
// self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
`default_nettype none
module lin_mode_host_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic tx_bit = 1'b1;
  logic wake_pin = 1'b0;
  logic bus_pull_dn = 1'b0;
  logic cmd_ready, cmd_err, wake_evt, rx_bit, txd_pin, en_pin, rxd_pin, gate, bus;
  lin_host_pkg::mode_t mode, dmode;
  int err_count = 0;
  int check_count = 0;
  int exp_m;
  int prev_m;
  logic [31:0] lfsr = 32'h7f88;

  always #5 clk = ~clk;

  lin_mode_host #(.FIRST_TXD_CYC(20), .SLEEP_DELAY_CYC(700)) u_lin_mode_host (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_bit(tx_bit),
    .cmd_ready(cmd_ready), .cmd_err(cmd_err), .wake_evt(wake_evt), .rx_bit(rx_bit), .mode(mode),
    .txd_pin(txd_pin), .en_pin(en_pin), .rxd_pin(rxd_pin), .regulator_gate_out(gate));

  lin_dev_model u_lin_dev_model (
    .clk(clk), .rst_n(rst_n), .txd(txd_pin), .en(en_pin), .wake_pin(wake_pin),
    .bus_pull_dn(bus_pull_dn), .rxd(rxd_pin), .gate(gate), .bus(bus), .dmode(dmode));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // mode encoding: 0 sleep, 1 awake, 2 normal, 3 wait slow, 4 slow, 5 fast; -1 means refused
  function automatic int ref_next(input int c);
    int n;
    n = -1;
    if ((c == 0 || c == 1) && exp_m <= 1) n = c ? 4 : 2;
    if (c == 2 && exp_m != 0) n = 0;
    if (c == 3 && (exp_m == 2 || exp_m == 4)) n = 5;
    if ((c == 3 || c == 4) && exp_m == 5) n = prev_m;
    return n;
  endfunction : ref_next

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic end_sim();
    $display("err_count=%0d check_count=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic tmo();
    err_count++;
    $display("Error at %0t: wait timed out", $time);
    end_sim();
  endtask : tmo

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_mode(input logic [2:0] got, input int exp);
    check_count++;
    if (got !== 3'(exp)) begin
      err_count++;
      $display("Error at %0t: mode %0d expected %0d", $time, got, exp);
    end
  endtask : chk_mode

  task automatic do_cmd(input int c);
    int n;
    int k;
    logic seen;
    n = ref_next(c);
    k = 0;
    seen = 1'b0;
    cmd_code = 3'(c);
    cmd_valid = 1'b1;
    step();
    cmd_valid = 1'b0;
    if (n < 0) begin
      repeat (3) begin
        seen = seen | (cmd_err === 1'b1);
        step();
      end
      chk_bit(seen, 1'b1);
    end else begin
      repeat (3) step();
      while (cmd_ready !== 1'b1) begin
        if (dmode === lin_host_pkg::MODE_WAIT_SLOW) chk_bit(rxd_pin, 1'b1);
        step();
        k++;
        if (k > 20000) tmo();
      end
      exp_m = n;
      if (n == 2 || n == 4) prev_m = n;
    end
    chk_mode(mode, exp_m);
    chk_mode(dmode, exp_m);
    chk_bit(en_pin, exp_m >= 2);
  endtask : do_cmd

  task automatic wait_wake();
    int k;
    k = 0;
    while (wake_evt !== 1'b1) begin
      step();
      k++;
      if (k > 20000) tmo();
    end
    exp_m = 1;
    repeat (2) step();
    chk_mode(mode, exp_m);
    chk_mode(dmode, exp_m);
  endtask : wait_wake

  initial begin
    exp_m = 1;
    prev_m = 2;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(txd_pin, 1'b1);
    chk_bit(en_pin, 1'b0);
    chk_bit(cmd_ready, 1'b0);
    rst_n = 1'b1;
    repeat (3) step();
    chk_mode(mode, exp_m);
    chk_bit(gate, 1'b1);
    chk_bit(rxd_pin, 1'b0);
    do_cmd(4);
    do_cmd(7);
    do_cmd(0);
    do_cmd(1);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      tx_bit = lfsr[0];
      bus_pull_dn = lfsr[1] & lfsr[2];
      repeat (12) step();
      chk_bit(rx_bit, lfsr[0] & ~(lfsr[1] & lfsr[2]));
      chk_bit(bus, lfsr[0] & ~(lfsr[1] & lfsr[2]));
    end
    tx_bit = 1'b1;
    bus_pull_dn = 1'b0;
    repeat (12) step();
    do_cmd(3);
    do_cmd(4);
    do_cmd(3);
    do_cmd(3);
    do_cmd(2);
    chk_bit(gate, 1'b0);
    do_cmd(2);
    wake_pin = 1'b1;
    repeat (1000) step();
    wake_pin = 1'b0;
    repeat (100) step();
    chk_mode(dmode, exp_m);
    wake_pin = 1'b1;
    wait_wake();
    do_cmd(1);
    do_cmd(0);
    do_cmd(3);
    do_cmd(4);
    do_cmd(2);
    bus_pull_dn = 1'b1;
    repeat (7100) step();
    bus_pull_dn = 1'b0;
    wait_wake();
    do_cmd(0);
    do_cmd(2);
    do_cmd(0);
    do_cmd(2);
    wake_pin = 1'b0;
    wait_wake();
    end_sim();
  end
endmodule : lin_mode_host_tb
`default_nettype wire
